// ===== design/bct_term_ctrl.sv
`timescale 1ns/1ps
`include "bct_defines.svh"
// Contract
// - Acknowledge, fault and halt are evaluated at even state N and again at N + 2.
// - Halt at N with fault by N + 2 and no acknowledge ends the cycle for a rerun.
// - After a fault end, release of fault and halt starts bus error handling.
// - After a rerun end with fault released before halt, the cycle is repeated.
// - After a rerun end with a wrong release order, vector number 0 is taken.
// - After a normal end with halt still held, the next cycle waits for its release.
// - After a normal end with fault still held, the next cycle ends as a bus error.
// - Fault is sampled from S0, acknowledge from S4; a fault end lands in S9, not S7.

module bct_term_ctrl
  import bct_pkg::*;
#(
  parameter int                    CLKS_PER_STATE = `BCT_CLKS_PER_STATE,
  parameter logic [`BCT_VEC_W-1:0] FAULT_VECTOR   = `BCT_VEC_BUS_FAULT
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  cycle_req,
  input  wire logic                  transfer_ack_n,
  input  wire logic                  bus_fault_n,
  input  wire logic                  halt_n,
  output logic                       cycle_busy,
  output logic                       cycle_extend,
  output logic [`BCT_ST_W-1:0]       bus_state,
  output logic                       cycle_done,
  output logic [1:0]                 term_kind,
  output logic                       fault_trap,
  output logic                       rerun_req,
  output logic                       illegal_trap,
  output logic [`BCT_VEC_W-1:0]      trap_vector
);

  bct_state_t            st_ff, nxt_st;
  bct_term_t             term_ff, nxt_term;
  logic                  fault_seen_ff, halt_prev_ff, sticky_ff, cyc_sticky_ff, fault_rel_ff;
  logic                  done_ff, ftrap_ff, rerun_ff, illegal_ff;
  logic [1:0]            kind_ff;
  logic [`BCT_VEC_W-1:0] vec_ff;
  logic                  step_en;

  // ----------------------------------------------------------------
  // Input decode
  // ----------------------------------------------------------------
  wire ack_now    = ~transfer_ack_n;
  wire fault_now  = ~bus_fault_n;
  wire halt_now   = ~halt_n;
  wire start      = (st_ff == BCT_IDLE) && cycle_req;
  wire running    = (st_ff == BCT_RUN);
  wire even_st    = ~bus_state[0];
  wire fault_any  = fault_seen_ff || fault_now;
  // Decision window opens at S4 on even states
  wire eval_pt    = running && step_en && even_st && (bus_state >= `BCT_ST_ACK_OPEN)
                    && (term_ff == BCT_TERM_NONE);
  wire take_fault = fault_any && (!ack_now || cyc_sticky_ff);
  wire end_pt     = running && step_en && (term_ff != BCT_TERM_NONE) &&
                    (bus_state == ((term_ff == BCT_TERM_NORMAL) ? `BCT_ST_END_NORMAL
                                                                : `BCT_ST_END_FAULT));
  wire rel_pt     = (st_ff == BCT_RELEASE) && step_en;
  wire both_rel   = !fault_now && !halt_now;
  wire bad_order  = (term_ff == BCT_TERM_RERUN) &&
                    ((!halt_now && fault_now) || (both_rel && !fault_rel_ff));
  wire good_rerun = (term_ff == BCT_TERM_RERUN) && both_rel && fault_rel_ff;
  wire wait_back  = running && (term_ff == BCT_TERM_NONE) && (bus_state == `BCT_ST_WAIT_BACK);

  assign cycle_busy   = running || (st_ff == BCT_RELEASE);
  assign cycle_extend = (st_ff == BCT_HOLD);
  assign cycle_done   = done_ff;
  assign term_kind    = kind_ff;
  assign fault_trap   = ftrap_ff;
  assign rerun_req    = rerun_ff;
  assign illegal_trap = illegal_ff;
  assign trap_vector  = vec_ff;

  // ----------------------------------------------------------------
  // Bus state pacing
  // ----------------------------------------------------------------
  bct_state_step #(
    .CLKS      (CLKS_PER_STATE)
  ) u_step (
    .core_clk  (core_clk),
    .rst       (rst),
    .restart   (start),
    .run       (cycle_busy),
    .wait_back (wait_back),
    .step_en   (step_en),
    .bus_state (bus_state)
  );

  // ----------------------------------------------------------------
  // Termination choice and next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    nxt_term = term_ff;
    unique case (st_ff)
      BCT_IDLE: begin
        if (start) begin
          nxt_st   = BCT_RUN;
          nxt_term = BCT_TERM_NONE;
        end
      end
      BCT_RUN: begin
        if (eval_pt && take_fault) begin
          nxt_term = (halt_now || halt_prev_ff) ? BCT_TERM_RERUN : BCT_TERM_FAULT;
        end else if (eval_pt && ack_now) begin
          nxt_term = BCT_TERM_NORMAL;
        end
        if (end_pt) begin
          if (term_ff != BCT_TERM_NORMAL) begin
            nxt_st = BCT_RELEASE;
          end else if (halt_now) begin
            nxt_st = BCT_HOLD;
          end else begin
            nxt_st = BCT_IDLE;
          end
        end
      end
      BCT_RELEASE: begin
        if (rel_pt && (both_rel || bad_order)) begin
          nxt_st = BCT_IDLE;
        end
      end
      BCT_HOLD: begin
        if (!halt_now) begin
          nxt_st = BCT_IDLE;
        end
      end
      default: nxt_st = BCT_IDLE;
    endcase
  end

  // State and term registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff   <= BCT_IDLE;
      term_ff <= BCT_TERM_NONE;
    end else begin
      st_ff   <= nxt_st;
      term_ff <= nxt_term;
    end
  end

  // ----------------------------------------------------------------
  // Sampling history and carry-over fault
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_seen_ff <= 1'b0;
      halt_prev_ff  <= 1'b0;
      sticky_ff     <= 1'b0;
      cyc_sticky_ff <= 1'b0;
      fault_rel_ff  <= 1'b0;
    end else begin
      if (start) begin
        fault_seen_ff <= sticky_ff && fault_now;
        cyc_sticky_ff <= sticky_ff && fault_now;
        halt_prev_ff  <= 1'b0;
        fault_rel_ff  <= 1'b0;
      end else if (running && step_en && even_st) begin
        fault_seen_ff <= fault_any;
        halt_prev_ff  <= halt_now;
      end else if (rel_pt && !fault_now) begin
        fault_rel_ff  <= 1'b1;
      end
      if (end_pt) begin
        sticky_ff <= (term_ff == BCT_TERM_NORMAL) && fault_now;
      end else if (!fault_now && !cycle_busy) begin
        sticky_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result pulses and vector
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_ff    <= 1'b0;
      kind_ff    <= 2'h0;
      ftrap_ff   <= 1'b0;
      rerun_ff   <= 1'b0;
      illegal_ff <= 1'b0;
      vec_ff     <= `BCT_VEC_ILLEGAL;
    end else begin
      done_ff    <= end_pt;
      ftrap_ff   <= rel_pt && both_rel && (term_ff == BCT_TERM_FAULT);
      rerun_ff   <= rel_pt && good_rerun;
      illegal_ff <= rel_pt && bad_order;
      if (end_pt) begin
        kind_ff <= term_ff;
      end
      if (rel_pt && bad_order) begin
        vec_ff <= `BCT_VEC_ILLEGAL;
      end else if (rel_pt && both_rel && (term_ff == BCT_TERM_FAULT)) begin
        vec_ff <= FAULT_VECTOR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_decide_even_only: assert property ($changed(term_ff) && term_ff != BCT_TERM_NONE
    |-> $past(step_en) && !$past(bus_state[0]) && $past(bus_state) >= `BCT_ST_ACK_OPEN)
    else $error("termination chosen outside an even state from S4");
  a_rerun_by_halt: assert property ($changed(term_ff) && term_ff == BCT_TERM_RERUN
    |-> $past(halt_now) || $past(halt_prev_ff))
    else $error("rerun chosen without halt");
  a_fault_trap_rel: assert property (fault_trap |-> $past(both_rel) && trap_vector == FAULT_VECTOR
    && kind_ff == BCT_TERM_FAULT)
    else $error("bus error trap without release of fault and halt");
  a_rerun_order: assert property (rerun_req |-> $past(fault_rel_ff) && $past(both_rel)
    && st_ff == BCT_IDLE)
    else $error("rerun without proper release order");
  a_illegal_vec: assert property (illegal_trap |-> trap_vector == `BCT_VEC_ILLEGAL
    && kind_ff == BCT_TERM_RERUN)
    else $error("illegal sequence not at vector 0");
  a_hold_blocks: assert property (st_ff == BCT_HOLD && halt_now |=> st_ff == BCT_HOLD)
    else $error("next cycle started while halt held");
  a_sticky_fault: assert property (done_ff && cyc_sticky_ff |-> kind_ff != BCT_TERM_NORMAL)
    else $error("carried-over fault ended normally");
  a_normal_at_s7: assert property (done_ff && kind_ff == BCT_TERM_NORMAL
    |-> $past(bus_state) == `BCT_ST_END_NORMAL)
    else $error("normal cycle did not end in S7");
  a_fault_at_s9: assert property (done_ff && kind_ff[1]
    |-> $past(bus_state) == `BCT_ST_END_FAULT && st_ff == BCT_RELEASE)
    else $error("fault cycle did not end in S9");

endmodule

// ===== pkg/bct_defines.svh
`ifndef BCT_DEFINES_SVH
`define BCT_DEFINES_SVH

// Bus state pacing: core clocks per bus state
`define BCT_CLKS_PER_STATE   2
// Bus state numbering
`define BCT_ST_W             4
`define BCT_ST_FAULT_OPEN    4'h0
`define BCT_ST_ACK_OPEN      4'h4
`define BCT_ST_WAIT_BACK     4'h5
`define BCT_ST_END_NORMAL    4'h7
`define BCT_ST_END_FAULT     4'h9
// Exception vector numbers
`define BCT_VEC_W            8
`define BCT_VEC_ILLEGAL      8'h00
`define BCT_VEC_BUS_FAULT    8'h02

`endif

// ===== pkg/bct_pkg.sv
package bct_pkg;

  typedef enum logic [2:0] {
    BCT_IDLE    = 3'b000,
    BCT_RUN     = 3'b001,
    BCT_RELEASE = 3'b010,
    BCT_HOLD    = 3'b011
  } bct_state_t;

  typedef enum logic [1:0] {
    BCT_TERM_NONE   = 2'b00,
    BCT_TERM_NORMAL = 2'b01,
    BCT_TERM_FAULT  = 2'b10,
    BCT_TERM_RERUN  = 2'b11
  } bct_term_t;

endpackage

// ===== design/bct_state_step.sv
`timescale 1ns/1ps
`include "bct_defines.svh"

module bct_state_step #(
  parameter int CLKS = `BCT_CLKS_PER_STATE
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  restart,
  input  wire logic                  run,
  input  wire logic                  wait_back,
  output logic                       step_en,
  output logic [`BCT_ST_W-1:0]       bus_state
);

  localparam int DW = (CLKS > 1) ? $clog2(CLKS) : 1;
  localparam logic [`BCT_ST_W-1:0] ST_ONE = {{(`BCT_ST_W-1){1'b0}}, 1'b1};

  // Refuse a pacing that cannot give one step per state
  if (CLKS < 1) begin : g_bad_clks
    $error("bct_state_step: CLKS must be at least 1");
  end

  logic [DW-1:0]         div_ff;
  logic [`BCT_ST_W-1:0]  state_ff;
  logic [DW-1:0]         nxt_div;
  logic [`BCT_ST_W-1:0]  nxt_state;

  // ----------------------------------------------------------------
  // Divider and bus state counter
  // ----------------------------------------------------------------
  // One pulse per bus state while a cycle is running
  assign step_en   = run && (div_ff == DW'(CLKS - 1));
  assign nxt_div   = (restart || !run || step_en) ? '0 : div_ff + DW'(1);
  assign nxt_state = restart   ? '0 :
                     !step_en  ? state_ff :
                     wait_back ? state_ff - ST_ONE :
                                 state_ff + ST_ONE;
  assign bus_state = state_ff;

  // Counter registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_ff   <= '0;
      state_ff <= '0;
    end else begin
      div_ff   <= nxt_div;
      state_ff <= nxt_state;
    end
  end

endmodule

// ===== verif/bct_ext_model.sv
`timescale 1ns/1ps
`include "bct_defines.svh"
module bct_ext_model (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 cycle_busy,
  input  wire logic                 cycle_done,
  input  wire logic [`BCT_ST_W-1:0] bus_state,
  input  wire logic [2:0]           mode,
  input  wire logic [3:0]           ack_wait,
  output logic                      transfer_ack_n,
  output logic                      bus_fault_n,
  output logic                      halt_n
);
  logic [5:0] rc_ff;
  logic [3:0] wc_ff;
  // Cycle phase decode
  wire st0  = cycle_busy && bus_state == 4'h0;
  wire late = cycle_busy && bus_state >= 4'h4;
  wire ackm = mode == 3'h0 || mode == 3'h4 || mode == 3'h5 || mode == 3'h6;
  wire ackt = late && wc_ff >= ack_wait;
  wire f_on = (st0 && mode inside {3'h1, 3'h2, 3'h3}) || (ackt && mode == 3'h5);
  wire f_off = (rc_ff == 6'h02 && mode inside {3'h1, 3'h2, 3'h6})
            || (rc_ff == 6'h06 && mode == 3'h3);
  wire h_off = (rc_ff == 6'h06 && mode == 3'h2) || (rc_ff == 6'h02 && mode == 3'h3)
            || (rc_ff == 6'h0A && mode == 3'h4);
  // Timers and driven lines; released lines idle high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rc_ff          <= 6'h3F;
      wc_ff          <= 4'h0;
      transfer_ack_n <= 1'b1;
      bus_fault_n    <= 1'b1;
      halt_n         <= 1'b1;
    end else begin
      rc_ff          <= cycle_done ? 6'h00 : rc_ff + {5'h00, rc_ff != 6'h3F};
      wc_ff          <= late ? wc_ff + {3'h0, wc_ff != 4'hF} : 4'h0;
      transfer_ack_n <= !(ackt && ackm);
      if (f_on) bus_fault_n <= 1'b0;
      else if (f_off) bus_fault_n <= 1'b1;
      if (st0 && mode inside {3'h2, 3'h3, 3'h4}) halt_n <= 1'b0;
      else if (h_off) halt_n <= 1'b1;
    end
  end
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
`include "bct_defines.svh"
module tb;
  import bct_pkg::*;
  logic                  core_clk, rst, cycle_req;
  logic [2:0]            mode, seen;
  logic [3:0]            ack_wait;
  logic [`BCT_ST_W-1:0]  top_st;
  int                    err_count, tests_run;
  wire                   ack_n, fault_n, halt_n, busy, ext, done, f_tr, rr, il;
  wire  [1:0]            kind;
  wire  [`BCT_ST_W-1:0]  bst;
  wire  [`BCT_VEC_W-1:0] vec;

  bct_term_ctrl #(.CLKS_PER_STATE(2)) i_bct_term_ctrl (
    .core_clk(core_clk), .rst(rst), .cycle_req(cycle_req),
    .transfer_ack_n(ack_n), .bus_fault_n(fault_n), .halt_n(halt_n),
    .cycle_busy(busy), .cycle_extend(ext), .bus_state(bst), .cycle_done(done),
    .term_kind(kind), .fault_trap(f_tr), .rerun_req(rr), .illegal_trap(il),
    .trap_vector(vec));
  bct_ext_model i_bct_ext_model (
    .core_clk(core_clk), .rst(rst), .cycle_busy(busy), .cycle_done(done),
    .bus_state(bst), .mode(mode), .ack_wait(ack_wait),
    .transfer_ack_n(ack_n), .bus_fault_n(fault_n), .halt_n(halt_n));

  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Trap pulse collector
  always @(posedge core_clk) seen <= seen | {il, rr, f_tr};

  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, s, e);
    end
  endtask
  // One bus cycle: start, track highest state, compare ending
  task run(input [2:0] m, input [3:0] w, input [1:0] tk, input [3:0] mx);
    int n;
    n = 0;
    seen = 3'h0;
    top_st = 4'h0;
    @(posedge core_clk);
    mode <= m;
    ack_wait <= w;
    cycle_req <= 1'b1;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    cycle_req <= 1'b0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
      if (done !== 1'b1 && busy === 1'b1 && bst > top_st) top_st = bst;
    end
    chk({7'h00, done}, 8'h01);
    chk({6'h00, kind}, {6'h00, tk});
    chk({4'h0, top_st}, {4'h0, mx});
  endtask
  // Follow-up actions after release of the lines
  task traps(input [2:0] ex, input [7:0] v);
    repeat (24) @(posedge core_clk);
    #1;
    chk({5'h00, seen}, {5'h00, ex});
    if (ex != 3'h0 && ex != 3'h2) chk(vec, v);
  endtask

  task t_normal;
    run(3'h0, 4'h0, 2'h1, 4'h7);
    run(3'h0, 4'h9, 2'h1, 4'h7);
    traps(3'h0, 8'h00);
  endtask
  task t_fault;
    run(3'h1, 4'h0, 2'h2, 4'h9);
    traps(3'h1, `BCT_VEC_BUS_FAULT);
  endtask
  task t_rerun;
    run(3'h2, 4'h0, 2'h3, 4'h9);
    traps(3'h2, 8'h00);
  endtask
  task t_wrong;
    run(3'h3, 4'h0, 2'h3, 4'h9);
    traps(3'h4, `BCT_VEC_ILLEGAL);
  endtask
  task t_hold;
    run(3'h4, 4'h0, 2'h1, 4'h7);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, ext}, 8'h01);
    // Requests while held off must not start a cycle
    @(posedge core_clk);
    cycle_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    cycle_req <= 1'b0;
    #1;
    chk({7'h00, busy}, 8'h00);
    traps(3'h0, 8'h00);
    chk({7'h00, ext}, 8'h00);
  endtask
  task t_carry;
    run(3'h5, 4'h0, 2'h1, 4'h7);
    traps(3'h0, 8'h00);
    run(3'h6, 4'h0, 2'h2, 4'h9);
    traps(3'h1, `BCT_VEC_BUS_FAULT);
  endtask

  task end_sim;
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    cycle_req = 1'b0;
    mode = 3'h0;
    ack_wait = 4'h0;
    seen = 3'h0;
    top_st = 4'h0;
    err_count = 0;
    tests_run = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_normal();
    t_fault();
    t_rerun();
    t_wrong();
    t_hold();
    t_carry();
    end_sim();
  end
  // Hang guard
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule
